// ---- seq_irq_entry_and_db_atomicity_test.sv ----
// Self-checking bench for the sequencer interrupt and delayed-branch block.
// Assumes the source model on the request lines and a bus slave that may insert wait states.
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD %0t mismatch %h vs %h", $time, (a), (e)); end end
module seq_irq_entry_and_db_atomicity_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] F_IDLE = 8'h80, F_JMP = 8'h40, F_CALL = 8'h20, F_DB = 8'h10;
    localparam logic [7:0] F_RTI = 8'h04, F_PUSH = 8'h02, F_POP = 8'h01;
    logic clk = 1'b0, rst = 1'b1, op_valid = 1'b0, op_taken = 1'b0, hsel = 1'b0;
    logic hwrite = 1'b0, irq_take, br_take, slot_squash, idle_out, stat_pop_vld, hresp;
    logic hreadyout;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, fire = 32'h0, irq_lines, r;
    logic [23:0] vec_addr, br_addr, last_vec, last_br, pc_run, pc_call, v;
    seqirq_pkg::seqirq_op_t op = '0;
    seqirq_pkg::seqirq_stat_t stat = '0, stat_pop, last_pop;
    int error_cnt = 0, n_tests = 0, takes = 0, brs = 0, sqs = 0, pops = 0, k, t, b, s;

    always #20 clk = ~clk;
    seqirq_src_model i_src (.clk(clk), .rst(rst), .fire(fire), .take(irq_take),
        .vec(vec_addr), .lines(irq_lines));
    seqirq_top i_dut (.CLK_SYS(clk), .SYS_RST(rst), .IRQ_IN(irq_lines), .OP(op),
        .OP_VALID(op_valid), .OP_TAKEN(op_taken), .STAT(stat), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .IRQ_TAKE(irq_take),
        .VEC_ADDR(vec_addr), .BR_TAKE(br_take), .BR_ADDR(br_addr), .SLOT_SQUASH(slot_squash),
        .IDLE_OUT(idle_out), .STAT_POP(stat_pop), .STAT_POP_VLD(stat_pop_vld));

    // Event recorder for the one-cycle pulses
    always @(posedge clk) begin
        if (irq_take === 1'b1) begin
            takes <= takes + 1;
            last_vec <= vec_addr;
        end
        if (br_take === 1'b1) begin
            brs <= brs + 1;
            last_br <= br_addr;
        end
        if (slot_squash === 1'b1) sqs <= sqs + 1;
        if (stat_pop_vld === 1'b1) begin
            pops <= pops + 1;
            last_pop <= stat_pop;
        end
    end

    function automatic logic [23:0] vec_of(input int i);
        return seqirq_pkg::VEC_BASE_DEF + (24'(i) << seqirq_pkg::VEC_SHIFT);
    endfunction

    // Single bus transfer; waits out any wait state, only the watchdog ends a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= seqirq_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do begin
            @(posedge clk);
        end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge clk);
        end while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic opx(input logic [7:0] f, input logic [23:0] pc, input logic [23:0] tg,
        input logic tk);
        @(posedge clk);
        op <= {f, pc, tg};
        op_valid <= 1'b1;
        op_taken <= tk;
        @(posedge clk);
        op_valid <= 1'b0;
    endtask

    task automatic run(input int n);
        repeat (n) opx(8'h0, pc_run, 24'h0, 1'b0);
    endtask

    task automatic fire_on(input logic [31:0] m);
        @(posedge clk);
        fire <= m;
        @(posedge clk);
        fire <= 32'h0;
    endtask

    task automatic rti_chk();
        int bb = brs;
        int pp = pops;
        opx(F_RTI, pc_run, 24'h0, 1'b0);
        repeat (4) @(posedge clk);
        `CHK(brs, bb + 1)
        `CHK(last_br, pc_run)
        `CHK(pops, pp + 1)
        `CHK(last_pop, stat)
    endtask

    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog sized well above the expected run
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    initial begin
        void'($urandom(82489));
        k = 8 + ($urandom % 24);
        pc_run = 24'($urandom);
        stat = {$urandom, $urandom, $urandom};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, seqirq_pkg::A_MASK, 32'h0);
        `CHK(r, seqirq_pkg::MASK_RESET)
        bus(1'b0, seqirq_pkg::A_PCSP, 32'h0);
        `CHK(r, 32'h0)
        bus(1'b1, seqirq_pkg::A_MASK, 32'h0);
        bus(1'b0, seqirq_pkg::A_MASK, 32'h0);
        `CHK(r, 32'h3)
        bus(1'b1, seqirq_pkg::A_LATCH, 32'h3);
        bus(1'b0, seqirq_pkg::A_LATCH, 32'h0);
        `CHK(r, 32'h0)
        bus(1'b0, 8'h40, 32'h0);
        `CHK(r, 32'h0)
        // Masked source stays latched, served once unmasked
        bus(1'b1, seqirq_pkg::A_MODE_CONTROL_REG_ONE, 32'h1 << seqirq_pkg::M1_IEN_BIT);
        fire_on(32'h1 << k);
        run(12);
        `CHK(takes, 0)
        bus(1'b0, seqirq_pkg::A_LATCH, 32'h0);
        `CHK(r[k], 1'b1)
        bus(1'b1, seqirq_pkg::A_MASK, 32'h3 | (32'h1 << k));
        run(12);
        `CHK(takes, 1)
        `CHK(last_vec, vec_of(k))
        bus(1'b0, seqirq_pkg::A_PCSP, 32'h0);
        `CHK(r, 32'h1)
        bus(1'b0, seqirq_pkg::A_PCTOP, 32'h0);
        `CHK(r[23:0], pc_run)
        bus(1'b0, seqirq_pkg::A_NESTP, 32'h0);
        `CHK(r, 32'h1 << k)
        bus(1'b0, seqirq_pkg::A_LATCH, 32'h0);
        `CHK(r[k], 1'b0)
        rti_chk();
        bus(1'b0, seqirq_pkg::A_NESTP, 32'h0);
        `CHK(r, 32'h0)
        // Global disable, then simultaneous pair resolved by priority
        bus(1'b1, seqirq_pkg::A_MODE_CONTROL_REG_ONE, 32'h0);
        bus(1'b1, seqirq_pkg::A_MASK, 32'hffff_ffff);
        fire_on(32'h88);
        run(12);
        `CHK(takes, 1)
        bus(1'b1, seqirq_pkg::A_MODE_CONTROL_REG_ONE, 32'h1 << seqirq_pkg::M1_IEN_BIT);
        run(12);
        `CHK(takes, 2)
        `CHK(last_vec, vec_of(3))
        rti_chk();
        run(12);
        `CHK(takes, 3)
        `CHK(last_vec, vec_of(7))
        rti_chk();
        // Request deferred across a group holding an idle slot
        t = takes;
        opx(F_DB | F_JMP, pc_run, 24'($urandom), 1'b1);
        fire_on(32'h1 << (8 + ($urandom % 24)));
        repeat (12) @(posedge clk);
        `CHK(takes, t)
        opx(F_IDLE, pc_run, 24'h0, 1'b0);
        repeat (8) @(posedge clk);
        `CHK(idle_out, 1'b1)
        `CHK(takes, t)
        run(8);
        `CHK(takes, t + 1)
        rti_chk();
        // Taken jump in first slot wins and drops the next slot
        b = brs;
        s = sqs;
        v = 24'($urandom);
        opx(F_DB | F_JMP, pc_run, 24'($urandom), 1'b1);
        opx(F_JMP, pc_run, v, 1'b1);
        run(3);
        `CHK(brs, b + 1)
        `CHK(last_br, v)
        `CHK(sqs, s + 1)
        opx(F_DB | F_JMP, pc_run, 24'($urandom), 1'b1);
        opx(F_DB | F_JMP, pc_run, 24'($urandom), 1'b0);
        run(4);
        `CHK(brs, b + 1)
        `CHK(sqs, s + 1)
        // Stack traffic inside delayed-call slots
        pc_call = 24'($urandom);
        opx(F_DB | F_CALL, pc_call, 24'($urandom), 1'b1);
        bus(1'b0, seqirq_pkg::A_PCSP, 32'h0);
        `CHK(r, 32'h1)
        bus(1'b0, seqirq_pkg::A_PCTOP, 32'h0);
        `CHK(r[23:0], pc_call + 24'(seqirq_pkg::RET_OFS_DB))
        opx(F_PUSH, v, v, 1'b0);
        bus(1'b0, seqirq_pkg::A_PCTOP, 32'h0);
        `CHK(r[23:0], v)
        run(1);
        opx(F_POP, v, v, 1'b0);
        bus(1'b0, seqirq_pkg::A_PCTOP, 32'h0);
        `CHK(r[23:0], pc_call + 24'(seqirq_pkg::RET_OFS_DB))
        opx(F_DB | F_CALL, pc_call, 24'($urandom), 1'b1);
        bus(1'b1, seqirq_pkg::A_PCTOP, {8'h0, v});
        run(2);
        bus(1'b0, seqirq_pkg::A_PCTOP, 32'h0);
        `CHK(r[23:0], v)
        summarize();
    end
endmodule
`default_nettype wire

// ---- seqirq_pkg.sv ----
// Package for the sequencer interrupt entry and delayed-branch atomicity block.
// Assumes a single core clock; shared by the block and its bench.
`default_nettype none
package seqirq_pkg;
    localparam int NIRQ = 32;
    localparam int PCW = 24;
    localparam int SPW = 5;
    localparam int STKD = 30;
    // Fixed priority positions of the non-maskable sources
    localparam int RST_BIT = 0;
    localparam int EMU_BIT = 1;
    localparam logic [31:0] NMI_BITS = 32'h0000_0003;
    // Vector table spacing in instructions, as a shift
    localparam int VEC_SHIFT = 2;
    localparam logic [PCW-1:0] VEC_BASE_DEF = 24'h090000;
    // Slot count of a group: delayed branch plus two slots
    localparam logic [1:0] DB_SLOTS = 2'h2;
    // Call return offsets: a delayed call returns past its two slots
    localparam int RET_OFS_DB = 3;
    localparam int RET_OFS_IMM = 1;
    // Mode control register one fields
    localparam int M1W = 32;
    localparam int M1_IEN_BIT = 12;
    localparam int M1_NEST_BIT = 11;
    localparam logic [M1W-1:0] M1_RESET = 32'h0000_0000;
    // Register bus offsets
    localparam logic [7:0] A_MODE_CONTROL_REG_ONE = 8'h00;
    localparam logic [7:0] A_LATCH = 8'h04;
    localparam logic [7:0] A_MASK = 8'h08;
    localparam logic [7:0] A_NESTP = 8'h0c;
    localparam logic [7:0] A_PCTOP = 8'h10;
    localparam logic [7:0] A_PCSP = 8'h14;
    localparam logic [7:0] A_VBASE = 8'h18;
    localparam logic [7:0] A_SSP = 8'h1c;
    localparam logic [31:0] MASK_RESET = NMI_BITS;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Instruction events from the pipeline, one cycle each
    typedef struct packed {
        logic idle;
        logic jump;
        logic call;
        logic db;
        logic rts;
        logic rti;
        logic push;
        logic pop;
        logic [PCW-1:0] pc;
        logic [PCW-1:0] target;
    } seqirq_op_t;

    typedef struct packed {
        logic [31:0] arith_status_x;
        logic [31:0] arith_status_y;
        logic [M1W-1:0] mode_control_reg_one;
    } seqirq_stat_t;
endpackage
`default_nettype wire

// ---- seqirq_src_model.sv ----
// Interrupt source model: level requests raised on command, dropped once serviced.
// Assumes the vector address carries the source index above the vector base.
`default_nettype none
module seqirq_src_model (
    input wire logic clk, // Core clock
    input wire logic rst, // Sync reset, high
    input wire logic [31:0] fire, // Pulse: raise these lines
    input wire logic take, // Vector call issued
    input wire logic [23:0] vec, // Vector address
    output logic [31:0] lines // Request lines
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [23:0] off = vec - seqirq_pkg::VEC_BASE_DEF;
    wire logic [31:0] ack = (take ? 32'h1 : 32'h0) << off[6:2];
    // Held until serviced, so a slow latch cannot hide behind a short pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            lines <= 32'h0;
        end else begin
            lines <= (lines | fire) & ~ack;
        end
    end
endmodule
`default_nettype wire

// ---- seqirq_top.sv ----
// Sequencer interrupt controller with delayed-branch atomic groups.
// Assumes an AHB-Lite master and an instruction pipeline reporting one op per cycle.
// Summary of operation
// [RULE1] Delayed branch plus two slots stays atomic
// [RULE2] Stack reads in slots show the push
// [RULE3] Idle in group stays idle
// [RULE4] Taken jump in slot wins, next slot dropped
// [RULE5] Exclusive conditional pair: second acts as nop
// [RULE6] Slot push lands above return address
// [RULE7] Slot write replaces call return address
// [RULE8] Controller works only with global enable
// [RULE9] Sources synchronised into latch register
// [RULE10] Respond when running, unmasked, enabled, top priority
// [RULE11] Service by call to spaced vector
// [RULE12] Entry pushes PC and status, clears latch
// [RULE13] Entry updates nest pointer per nesting mode
// [RULE14] Return pops PC, status, clears pointer bit
// [RULE15] Reset and emulator are non-maskable
// [RULE16] Masked request stays latched until unmasked
// [RULE17] Global and per-source masking
// [RULE18] Reset masks all maskable, empties stack
// [RULE19] Bit 0 highest, bit 31 lowest priority
// [RULE20] Latch held clear while its routine runs
// [RULE21] Deferred request taken after second slot
//
// Our own choices: the register addresses and the AHB-Lite register port.
`default_nettype none
module seqirq_top #(
    parameter int NIRQ = seqirq_pkg::NIRQ
) (
    input wire logic CLK_SYS, // Core clock
    input wire logic SYS_RST, // Synchronous reset, high
    input wire logic [NIRQ-1:0] IRQ_IN, // Asynchronous interrupt sources
    input wire seqirq_pkg::seqirq_op_t OP, // Retired instruction event
    input wire logic OP_VALID, // OP holds an instruction
    input wire logic OP_TAKEN, // Branch in OP is taken
    input wire seqirq_pkg::seqirq_stat_t STAT, // Live status registers
    input wire logic HSEL, // AHB select
    input wire logic [31:0] HADDR, // AHB address
    input wire logic [1:0] HTRANS, // AHB transfer type
    input wire logic HWRITE, // AHB write
    input wire logic [2:0] HSIZE, // AHB size
    input wire logic [31:0] HWDATA, // AHB write data
    input wire logic HREADY, // AHB bus ready
    output logic [31:0] HRDATA, // AHB read data
    output logic HREADYOUT, // AHB slave ready
    output logic HRESP, // AHB response, always OKAY
    output logic IRQ_TAKE, // Pulse: vector call issued
    output logic [seqirq_pkg::PCW-1:0] VEC_ADDR, // Vector address
    output logic BR_TAKE, // Pulse: branch redirect issued
    output logic [seqirq_pkg::PCW-1:0] BR_ADDR, // Branch or return address
    output logic SLOT_SQUASH, // Pulse: next slot not executed
    output logic IDLE_OUT, // Core is idled
    output seqirq_pkg::seqirq_stat_t STAT_POP, // Status restored at return
    output logic STAT_POP_VLD // Pulse: STAT_POP valid
);
    localparam int PCW = seqirq_pkg::PCW;
    localparam int SPW = seqirq_pkg::SPW;
    localparam int STKD = seqirq_pkg::STKD;

    // Latch, mask and pointer registers are one bus word wide
    if (NIRQ != 32) begin : g_nirq_chk
        $error("seqirq_top supports 32 sources only");
    end

    // Priority encoder, lowest index wins
    function automatic logic [4:0] pick(input logic [31:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) r = 5'(i);
        end
        return r;
    endfunction

    // Three-stage synchronisers; a level counts once stages two and three agree
    logic [31:0] s1_q, s2_q, s3_q, lvl_q;
    always_ff @(posedge CLK_SYS) begin
        s1_q <= IRQ_IN;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end
    // Accepted level; resets to the idle low pin level, so no false edge
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            lvl_q <= 32'h0;
        end else begin
            lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
        end
    end
    wire logic [31:0] irq_rise = s2_q & s3_q & ~lvl_q; // [RULE9]

    // Register state
    logic [31:0] mode_control_reg_one_q, latch_q, mask_q, nestp_q, latch_d;
    logic [PCW-1:0] vbase_q;
    logic [PCW-1:0] pc_stack_top_q [STKD];
    logic [SPW-1:0] pcsp_q, pcsp_d;
    seqirq_pkg::seqirq_stat_t ststk_q [STKD];
    logic [SPW-1:0] ssp_q;
    logic [1:0] grp_q, grp_d;
    logic idle_q;
    logic [31:0] svc_q;

    // AHB address phase capture
    logic wr_q, rd_q;
    logic [7:0] ad_q;
    wire logic ahb_go = HSEL & HREADY & (HTRANS == seqirq_pkg::HTRANS_NONSEQ);
    wire logic [7:0] ad_w = ad_q;
    wire logic m1_wr = wr_q & (ad_w == seqirq_pkg::A_MODE_CONTROL_REG_ONE);
    wire logic lt_wr = wr_q & (ad_w == seqirq_pkg::A_LATCH);
    wire logic mk_wr = wr_q & (ad_w == seqirq_pkg::A_MASK);
    wire logic np_wr = wr_q & (ad_w == seqirq_pkg::A_NESTP);
    wire logic pt_wr = wr_q & (ad_w == seqirq_pkg::A_PCTOP);
    wire logic vb_wr = wr_q & (ad_w == seqirq_pkg::A_VBASE);

    // Group tracking: a delayed branch opens two slots
    wire logic in_grp = grp_q != 2'h0;
    wire logic op_db = OP_VALID & OP.db & (OP.jump | OP.call | OP.rts);
    wire logic slot_br = OP_VALID & in_grp & (OP.jump | OP.call) & OP_TAKEN;
    // A delayed branch in a slot never reopens the group: the exclusive twin is a nop
    assign grp_d = (op_db & ~in_grp) ? seqirq_pkg::DB_SLOTS : // [RULE1] [RULE5]
                   (slot_br ? 2'h0 : // [RULE4]
                   (in_grp & OP_VALID ? grp_q - 2'h1 : grp_q)); // [RULE21]

    // Recognition conditions
    wire logic gen = mode_control_reg_one_q[seqirq_pkg::M1_IEN_BIT]; // [RULE8]
    wire logic nest = mode_control_reg_one_q[seqirq_pkg::M1_NEST_BIT];
    wire logic [31:0] eff_mask = mask_q | seqirq_pkg::NMI_BITS; // [RULE15]
    wire logic [4:0] hi_nest = pick(nestp_q);
    wire logic [31:0] nest_blk = nestp_q == 32'h0 ? 32'h0 :
        (nest ? ~((32'h1 << hi_nest) - 32'h1) : 32'hffff_ffff); // [RULE13]
    wire logic [31:0] cand = latch_q & eff_mask & ~nest_blk; // [RULE16] [RULE17]
    wire logic [4:0] win = pick(cand); // [RULE19]
    wire logic can_run = (OP_VALID | idle_q) & ~in_grp & ~op_db; // [RULE3]
    wire logic take = gen & (cand != 32'h0) & can_run & ~OP.rti; // [RULE10]
    wire logic [PCW-1:0] vec = vbase_q + (PCW'(win) << seqirq_pkg::VEC_SHIFT); // [RULE11]
    wire logic do_rti = OP_VALID & OP.rti & ~in_grp;
    wire logic [4:0] rti_bit = pick(nestp_q);

    // PC stack pointer movement
    wire logic call_push = OP_VALID & OP.call & OP_TAKEN & ~in_grp;
    wire logic ex_push = OP_VALID & OP.push;
    wire logic ex_pop = OP_VALID & OP.pop;
    wire logic rts_pop = OP_VALID & OP.rts & OP_TAKEN & ~in_grp;
    wire logic n_push = call_push | ex_push | take; // [RULE6]
    wire logic n_pop = ex_pop | rts_pop | do_rti;
    assign pcsp_d = n_push && !n_pop ? pcsp_q + 5'h01 :
                    (n_pop && !n_push ? pcsp_q - 5'h01 : pcsp_q); // [RULE2]
    wire logic [SPW-1:0] top_ix = pcsp_q - 5'h01;
    wire logic [PCW-1:0] pc_top = pcsp_q == 5'h00 ? '0 : pc_stack_top_q[top_ix];
    wire logic [PCW-1:0] ret_ofs = OP.db ? PCW'(seqirq_pkg::RET_OFS_DB) :
        PCW'(seqirq_pkg::RET_OFS_IMM);
    wire logic [PCW-1:0] push_val = (call_push && !take) ? OP.pc + ret_ofs : OP.pc;

    // Latch update; hardware set wins over software clear
    wire logic [31:0] take_bit = take ? (32'h1 << win) : 32'h0;
    always_comb begin
        latch_d = latch_q;
        if (lt_wr) latch_d = (HWDATA & ~seqirq_pkg::NMI_BITS) | (latch_q & seqirq_pkg::NMI_BITS);
        // Clearing starts with the vector call itself, so a same-cycle edge is dropped
        latch_d = (latch_d & ~take_bit & ~svc_q) | (irq_rise & ~svc_q & ~take_bit); // [RULE20]
    end

    // Bus read mux
    wire logic [31:0] rmux =
        ad_w == seqirq_pkg::A_MODE_CONTROL_REG_ONE ? mode_control_reg_one_q :
        ad_w == seqirq_pkg::A_LATCH ? latch_q :
        ad_w == seqirq_pkg::A_MASK ? mask_q :
        ad_w == seqirq_pkg::A_NESTP ? nestp_q :
        ad_w == seqirq_pkg::A_PCTOP ? 32'(pc_top) :
        ad_w == seqirq_pkg::A_PCSP ? 32'(pcsp_q) :
        ad_w == seqirq_pkg::A_VBASE ? 32'(vbase_q) :
        ad_w == seqirq_pkg::A_SSP ? 32'(ssp_q) : 32'h0;

    // Bus phase registers; writes have no wait, reads one for the registered mux
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            ad_q <= 8'h00;
        end else begin
            wr_q <= ahb_go & HWRITE;
            rd_q <= ahb_go & ~HWRITE;
            ad_q <= ahb_go ? HADDR[7:0] : ad_q;
        end
    end

    // Control registers
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            mode_control_reg_one_q <= seqirq_pkg::M1_RESET;
            mask_q <= seqirq_pkg::MASK_RESET; // [RULE18]
            latch_q <= 32'h0;
            nestp_q <= 32'h0;
            vbase_q <= seqirq_pkg::VEC_BASE_DEF;
            grp_q <= 2'h0;
            idle_q <= 1'b0;
            svc_q <= 32'h0;
        end else begin
            mode_control_reg_one_q <= m1_wr ? HWDATA : mode_control_reg_one_q;
            mask_q <= mk_wr ? (HWDATA | seqirq_pkg::NMI_BITS) : mask_q;
            latch_q <= latch_d;
            nestp_q <= np_wr ? (HWDATA | take_bit) :
                ((nestp_q | take_bit) & ~(do_rti ? (32'h1 << rti_bit) : 32'h0)); // [RULE14]
            vbase_q <= vb_wr ? HWDATA[PCW-1:0] : vbase_q;
            grp_q <= grp_d;
            idle_q <= take ? 1'b0 : ((OP_VALID & OP.idle) ? 1'b1 : idle_q); // [RULE3]
            svc_q <= (svc_q | take_bit) & ~(do_rti ? (32'h1 << rti_bit) : 32'h0);
        end
    end

    // PC stack and status stack storage
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            pcsp_q <= 5'h00; // [RULE18]
            ssp_q <= 5'h00;
        end else begin
            pcsp_q <= pcsp_d;
            if (n_push && !n_pop) pc_stack_top_q[pcsp_q] <= push_val;
            if (pt_wr && pcsp_q != 5'h00) pc_stack_top_q[top_ix] <= HWDATA[PCW-1:0]; // [RULE7]
            if (take) begin
                ststk_q[ssp_q] <= STAT; // [RULE12]
                ssp_q <= ssp_q + 5'h01;
            end else if (do_rti && ssp_q != 5'h00) begin
                ssp_q <= ssp_q - 5'h01;
            end
        end
    end

    // Outputs to pipeline and bus
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            HRDATA <= 32'h0;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            IRQ_TAKE <= 1'b0;
            VEC_ADDR <= '0;
            BR_TAKE <= 1'b0;
            BR_ADDR <= '0;
            SLOT_SQUASH <= 1'b0;
            IDLE_OUT <= 1'b0;
            STAT_POP <= '0;
            STAT_POP_VLD <= 1'b0;
        end else begin
            HRDATA <= (ahb_go & ~HWRITE) ? 32'h0 : (rd_q ? rmux : HRDATA);
            HREADYOUT <= ~(ahb_go & ~HWRITE);
            HRESP <= 1'b0;
            IRQ_TAKE <= take; // [RULE11]
            VEC_ADDR <= take ? vec : VEC_ADDR;
            BR_TAKE <= do_rti | slot_br;
            BR_ADDR <= do_rti ? pc_top : (slot_br ? OP.target : BR_ADDR); // [RULE14] [RULE4]
            SLOT_SQUASH <= slot_br & (grp_q == seqirq_pkg::DB_SLOTS); // [RULE4]
            IDLE_OUT <= take ? 1'b0 : ((OP_VALID & OP.idle) ? 1'b1 : idle_q);
            STAT_POP <= (do_rti && ssp_q != 5'h00) ? ststk_q[ssp_q - 5'h01] : STAT_POP;
            STAT_POP_VLD <= do_rti;
        end
    end

    // Checks
    chk_group_blocks: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE1]
        in_grp |-> !take) else $error("service inside delayed group");
    chk_gen_blocks: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE8]
        !gen |-> !take) else $error("service with global enable off");
    chk_take_pulse: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE11]
        take |=> IRQ_TAKE && VEC_ADDR == $past(vec)) else $error("vector not issued");
    chk_push_count: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE12]
        (take && !n_pop) |=> pcsp_q == $past(pcsp_q) + 5'h01) else $error("no push");
    chk_latch_clr: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE20]
        take |=> !latch_q[$past(win)]) else $error("latch not cleared");
    chk_nest_set: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE13]
        (take && !np_wr) |=> nestp_q[$past(win)]) else $error("nest bit missing");
    chk_prio_order: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE19]
        take |-> ((cand & ((32'h1 << win) - 32'h1)) == 32'h0)) else $error("priority");
    chk_nmi_mask: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE15]
        mask_q[seqirq_pkg::RST_BIT] && mask_q[seqirq_pkg::EMU_BIT]) else $error("nmi masked");
    chk_idle_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE3]
        (idle_q && in_grp) |=> idle_q) else $error("woke inside group");
    // Slot bookkeeping: a first-slot branch must redirect and drop the second slot
    chk_sq_first: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE4]
        (slot_br && grp_q == seqirq_pkg::DB_SLOTS) |=>
        SLOT_SQUASH && BR_ADDR == $past(OP.target)) else $error("slot jump not squashing");
    chk_db_no_reopen: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE5]
        (op_db && in_grp && !slot_br) |=> grp_q == $past(grp_q) - 2'h1)
        else $error("slot branch reopened group");
    // Return path and continuous latch clearing
    chk_rti_return: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE14]
        do_rti |=> BR_TAKE && BR_ADDR == $past(pc_top) && STAT_POP_VLD)
        else $error("return not issued");
    chk_svc_clear: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE20]
        svc_q != 32'h0 |=> (latch_q & $past(svc_q)) == 32'h0) else $error("in-service relatched");
    // No disable here: the check looks at the first edge after release
    chk_reset_state: assert property (@(posedge CLK_SYS) // [RULE18]
        $fell(SYS_RST) |-> pcsp_q == 5'h00 && mask_q == seqirq_pkg::MASK_RESET)
        else $error("reset state wrong");
    cov_take: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) take);
    cov_defer: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
        in_grp && cand != 32'h0 && gen ##[1:3] take);
    cov_rti: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) do_rti);
    cov_squash: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) SLOT_SQUASH);
    cov_idle_wake: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) idle_q && take);
endmodule
`default_nettype wire
